// File: design/irq_bank_defines.svh
/*
 * Register offsets, field positions, masks and reset values of the
 * interrupt enable bank.
 * Assumes it is included by its bare name before any use.
 */
`ifndef IRQ_BANK_DEFINES_SVH
`define IRQ_BANK_DEFINES_SVH

// Address groups, taken from byte address bits 7:4.
`define GRP_ENABLE      4'h0
`define GRP_STATUS      4'h1
`define GRP_CLEAR       4'h2
`define GRP_MISC        4'h3

// Word slots inside the miscellaneous group, byte address bits 3:2.
`define MISC_PRIO_SEL   2'h0
`define MISC_PRIO_DATA  2'h1
`define MISC_ARB        2'h2

// Implemented bits of each enable word; all other bits read as zero.
`define MASK_WORD_ONE   16'h000b
`define MASK_WORD_TWO   16'hdfff
`define MASK_WORD_THREE 16'h21ff
`define MASK_WORD_FOUR  16'h00f6

// Reset values.
`define ENABLE_RESET    16'h0000
`define FLAG_RESET      16'h0000
`define PRIO_RESET      3'h4
`define PRIO_OFF        3'h0

// Field positions in the arbitration readback word.
`define ARB_VALID_BIT   9
`define ARB_LEVEL_LSB   6

`endif

// File: design/irq_bank_pkg.sv
/*
 * Types shared by the interrupt enable bank modules.
 * Assumes nothing of its surroundings.
 */
package irq_bank_pkg;

  // One sixteen bit register word.
  typedef logic [15:0] word_t;

  // One three bit priority field.
  typedef logic [2:0] prio_t;

  // Bus handshake states, Gray coded along idle to acknowledge.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACK  = 2'b01
  } bus_state_t;

endpackage : irq_bank_pkg

// File: design/irq_enable_word.sv
/*
 * One software enable word with a fixed mask of implemented bits.
 * Assumes a synchronous write strobe with byte enables from the bus slave.
 */
`timescale 1ns/1ns
`default_nettype none
`include "irq_bank_defines.svh"

module irq_enable_word #(
  parameter irq_bank_pkg::word_t MASK = 16'h0000  // Implemented bits.
) (
  input  wire  logic                clk_i,        // System clock.
  input  wire  logic                rst_n_i,      // Synchronised reset.
  input  wire  logic                wr_en_i,      // Write strobe.
  input  wire  logic [1:0]          be_i,         // Byte enables.
  input  wire  irq_bank_pkg::word_t wdata_i,      // Write data.
  output var   irq_bank_pkg::word_t q_o           // Stored enables.
);
  import irq_bank_pkg::*;

  word_t q_r;    // Stored enable bits.
  word_t q_nxt;  // Next value.
  word_t lane;   // Byte lanes that the write touches.

  // Merge written lanes, keeping unimplemented bits at zero.
  always_comb begin
    lane  = {{8{be_i[1]}}, {8{be_i[0]}}};
    q_nxt = q_r;
    if (wr_en_i) begin
      q_nxt = ((q_r & ~lane) | (wdata_i & lane)) & MASK;
    end
  end

  // Register the enables; power-on clears them all.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r <= `ENABLE_RESET;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;

  property p_unimpl_zero;
    @(posedge clk_i) disable iff (!rst_n_i) wr_en_i |=> (q_r & ~MASK) == 16'h0000;
  endproperty
  a_unimpl_zero : assert property (p_unimpl_zero)
    else $error("Unimplemented enable bit became set.");

  property p_write_kept;
    @(posedge clk_i) disable iff (!rst_n_i)
      (wr_en_i && be_i == 2'b11) |=> (q_r == ($past(wdata_i) & MASK))
        ##1 (q_r == ($past(wdata_i, 2) & MASK));
  endproperty
  a_write_kept : assert property (p_write_kept)
    else $error("Enable word does not hold the written value.");

  property p_reset_clear;
    @(posedge clk_i) $rose(rst_n_i) |-> q_r == 16'h0000;
  endproperty
  a_reset_clear : assert property (p_reset_clear)
    else $error("Enable word not cleared by reset.");

endmodule : irq_enable_word
`default_nettype wire

// File: design/irq_flag_word.sv
/*
 * One word of sticky interrupt status flags.
 * Assumes request pulses from peripherals and clear pulses from the bus slave.
 */
`timescale 1ns/1ns
`default_nettype none
`include "irq_bank_defines.svh"

module irq_flag_word #(
  parameter irq_bank_pkg::word_t MASK = 16'h0000  // Implemented bits.
) (
  input  wire  logic                clk_i,    // System clock.
  input  wire  logic                rst_n_i,  // Synchronised reset.
  input  wire  irq_bank_pkg::word_t set_i,    // Request pulses.
  input  wire  irq_bank_pkg::word_t clr_i,    // Software clear bits.
  output var   irq_bank_pkg::word_t flag_o    // Sticky flags.
);
  import irq_bank_pkg::*;

  word_t flag_r;    // Sticky flags.
  word_t flag_nxt;  // Next value.

  // A request in the same cycle as a clear keeps the flag set.
  always_comb begin
    flag_nxt = ((flag_r & ~clr_i) | set_i) & MASK;
  end

  // Register the flags.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_r <= `FLAG_RESET;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag_o = flag_r;

  property p_set_wins;
    @(posedge clk_i) disable iff (!rst_n_i)
      (set_i & MASK) != 16'h0000 |=> (flag_r & $past(set_i & MASK)) == $past(set_i & MASK);
  endproperty
  a_set_wins : assert property (p_set_wins)
    else $error("Request lost instead of setting its flag.");

  property p_clear_only;
    @(posedge clk_i) disable iff (!rst_n_i)
      (clr_i & ~set_i & MASK) != 16'h0000 |=> (flag_r & $past(clr_i & ~set_i)) == 16'h0000;
  endproperty
  a_clear_only : assert property (p_clear_only)
    else $error("Flag survived a clear without a request.");

endmodule : irq_flag_word
`default_nettype wire

// File: design/interrupt_enable_bank.sv
/*
 * Interrupt enable bank: four enable words, their sticky status flags,
 * per-source priorities and a highest-priority pending selector,
 * reached over an Avalon-MM slave with waitrequest.
 * Assumes one 20 MHz clock, peripherals pulsing SRC_REQ_I for one
 * cycle per event, and a master that holds its request until it sees
 * waitrequest low.
 */
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "irq_bank_defines.svh"

module interrupt_enable_bank (
  input  wire  logic                 CLK_I,              // System clock.
  input  wire  logic                 RESETN_I,           // Power-on reset.
  input  wire  logic [7:0]           AVS_ADDRESS_I,      // Byte address.
  input  wire  logic                 AVS_READ_I,         // Read request.
  input  wire  logic                 AVS_WRITE_I,        // Write request.
  input  wire  logic [3:0]           AVS_BYTEENABLE_I,   // Byte enables.
  input  wire  logic [31:0]          AVS_WRITEDATA_I,    // Write data.
  output var   logic [31:0]          AVS_READDATA_O,     // Read data.
  output var   logic                 AVS_WAITREQUEST_O,  // Bus stall.
  input  wire  logic [63:0]          SRC_REQ_I,          // Source pulses.
  output var   logic                 IRQ_O,              // Level interrupt.
  output var   logic                 ARB_VALID_O,        // Winner valid.
  output var   logic [5:0]           ARB_SOURCE_O,       // Winner index.
  output var   irq_bank_pkg::prio_t  ARB_LEVEL_O         // Winner level.
);
  import irq_bank_pkg::*;

  // ****************************************************************
  // Reset release
  // ****************************************************************

  logic rst_meta_r;  // First stage of the reset release.
  logic rst_n;       // Released reset used by the whole block.

  // Assert at once, release after two clock edges.
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ****************************************************************
  // Implemented bit masks and source layout
  // ****************************************************************

  // Bit 3 change notice, bit 2 empty, bits 1 and 0 i2c one.
  localparam word_t MASK_ONE   = `MASK_WORD_ONE;
  // Timer six, dma four, compare eight to five, capture six to three,
  // dma three, can one, spi two; bit 13 empty.
  localparam word_t MASK_TWO   = `MASK_WORD_TWO;
  // Dma five, can two, pins four and three, timers nine to seven, i2c two.
  localparam word_t MASK_THREE = `MASK_WORD_THREE;
  // Can transmit, dma seven and six, uart errors; upper byte empty.
  localparam word_t MASK_FOUR  = `MASK_WORD_FOUR;
  localparam word_t MASKS [4]  = '{MASK_ONE, MASK_TWO, MASK_THREE, MASK_FOUR};

  logic [63:0] impl_mask;  // Implemented positions, word one lowest.
  assign impl_mask = {MASK_FOUR, MASK_THREE, MASK_TWO, MASK_ONE};

  // ****************************************************************
  // Bus decode
  // ****************************************************************

  bus_state_t state_r;    // Handshake state.
  bus_state_t state_nxt;  // Next handshake state.
  logic       req;        // A read or write is pending.
  logic       commit;     // A write takes effect this edge.
  logic [3:0] grp;        // Address group.
  logic [1:0] slot;       // Word slot inside the group.
  logic [1:0] be;         // Byte enables of the sixteen bit lanes.
  word_t      wdata;      // Low half of the write data.

  assign req    = AVS_READ_I | AVS_WRITE_I;
  assign grp    = AVS_ADDRESS_I[7:4];
  assign slot   = AVS_ADDRESS_I[3:2];
  assign be     = AVS_BYTEENABLE_I[1:0];
  assign wdata  = AVS_WRITEDATA_I[15:0];
  assign commit = (state_r == ST_ACK) && AVS_WRITE_I;

  // Every access stalls one cycle, then completes.
  assign AVS_WAITREQUEST_O = req && (state_r == ST_IDLE);

  // Step from idle to acknowledge on a request and straight back.
  always_comb begin
    case (state_r)
      ST_IDLE: begin
        state_nxt = req ? ST_ACK : ST_IDLE;
      end
      ST_ACK: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Register the handshake state.
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Enable words and status flags
  // ****************************************************************

  word_t en_q   [4];  // Enable words one to four.
  word_t flag_q [4];  // Status flag words one to four.
  word_t clr_w  [4];  // Clear bits for each flag word.
  logic [63:0] en_all;    // Flattened enables.
  logic [63:0] flag_all;  // Flattened flags.

  for (genvar g = 0; g < 4; g++) begin : g_word
    logic wr_en;  // Write strobe of this enable word.

    // Enable word writes, read back and masking.
    assign wr_en = commit && grp == `GRP_ENABLE && slot == 2'(g);

    // Clear bits come from a write to the matching clear word.
    assign clr_w[g] = (commit && grp == `GRP_CLEAR && slot == 2'(g))
                      ? (wdata & {{8{be[1]}}, {8{be[0]}}}) : 16'h0000;

    irq_enable_word #(.MASK(MASKS[g])) u_enable (
      .clk_i   (CLK_I),
      .rst_n_i (rst_n),
      .wr_en_i (wr_en),
      .be_i    (be),
      .wdata_i (wdata),
      .q_o     (en_q[g])
    );

    // Flags are set whatever the enable holds.
    irq_flag_word #(.MASK(MASKS[g])) u_flag (
      .clk_i   (CLK_I),
      .rst_n_i (rst_n),
      .set_i   (SRC_REQ_I[16*g +: 16]),
      .clr_i   (clr_w[g]),
      .flag_o  (flag_q[g])
    );

    assign en_all[16*g +: 16]   = en_q[g];
    assign flag_all[16*g +: 16] = flag_q[g];
  end

  // ****************************************************************
  // Priority storage
  // ****************************************************************

  prio_t       prio_r   [64];  // Priority of each source position.
  prio_t       prio_nxt [64];  // Next priorities.
  logic [5:0]  sel_r;          // Source chosen for priority access.
  logic [5:0]  sel_nxt;        // Next selection.

  // Select register and indexed priority write.
  always_comb begin
    sel_nxt = sel_r;
    for (int i = 0; i < 64; i++) begin
      prio_nxt[i] = prio_r[i];
    end
    if (commit && grp == `GRP_MISC && be[0]) begin
      if (slot == `MISC_PRIO_SEL) begin
        sel_nxt = wdata[5:0];
      end else if (slot == `MISC_PRIO_DATA && impl_mask[sel_r]) begin
        prio_nxt[sel_r] = wdata[2:0];
      end
    end
  end

  // Register selection and priorities.
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sel_r <= 6'h00;
      for (int i = 0; i < 64; i++) begin
        prio_r[i] <= `PRIO_RESET;
      end
    end else begin
      sel_r  <= sel_nxt;
      prio_r <= prio_nxt;
    end
  end

  // ****************************************************************
  // Arbitration and interrupt output
  // ****************************************************************

  logic        arb_valid_nxt;  // Some source may be presented.
  logic [5:0]  arb_src_nxt;    // Index of the winner.
  prio_t       arb_lvl_nxt;    // Level of the winner.
  logic        irq_nxt;        // Any enabled flag set.
  logic [63:0] pend;           // Flag and enable both set.

  assign pend = flag_all & en_all;

  // Highest level wins, lowest index breaks a tie; level zero never wins.
  always_comb begin
    arb_valid_nxt = 1'b0;
    arb_src_nxt   = 6'h00;
    arb_lvl_nxt   = `PRIO_OFF;
    for (int i = 0; i < 64; i++) begin
      if (pend[i] && prio_r[i] > arb_lvl_nxt) begin
        arb_valid_nxt = 1'b1;
        arb_src_nxt   = 6'(i);
        arb_lvl_nxt   = prio_r[i];
      end
    end
    irq_nxt = |pend;
  end

  // Register the arbitration result and the interrupt level.
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ARB_VALID_O  <= 1'b0;
      ARB_SOURCE_O <= 6'h00;
      ARB_LEVEL_O  <= `PRIO_OFF;
      IRQ_O        <= 1'b0;
    end else begin
      ARB_VALID_O  <= arb_valid_nxt;
      ARB_SOURCE_O <= arb_src_nxt;
      ARB_LEVEL_O  <= arb_lvl_nxt;
      IRQ_O        <= irq_nxt;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************

  logic [31:0] rdata_nxt;  // Value chosen for the pending read.

  // Capture read data in the stall cycle so it stands at the answer.
  always_comb begin
    rdata_nxt = AVS_READDATA_O;
    if (state_r == ST_IDLE && AVS_READ_I) begin
      rdata_nxt = 32'h0000_0000;
      case (grp)
        `GRP_ENABLE: begin
          rdata_nxt = {16'h0000, en_q[slot]};
        end
        `GRP_STATUS: begin
          rdata_nxt = {16'h0000, flag_q[slot]};
        end
        `GRP_MISC: begin
          if (slot == `MISC_PRIO_SEL) begin
            rdata_nxt = {26'h0, sel_r};
          end else if (slot == `MISC_PRIO_DATA) begin
            rdata_nxt = impl_mask[sel_r] ? {29'h0, prio_r[sel_r]} : 32'h0;
          end else if (slot == `MISC_ARB) begin
            rdata_nxt[`ARB_VALID_BIT]                      = ARB_VALID_O;
            rdata_nxt[`ARB_LEVEL_LSB +: 3]                 = ARB_LEVEL_O;
            rdata_nxt[5:0]                                 = ARB_SOURCE_O;
          end
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  // Register read data.
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      AVS_READDATA_O <= 32'h0000_0000;
    end else begin
      AVS_READDATA_O <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  logic [63:0] pend_d_r;  // Pending set one cycle back, for checks only.

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      pend_d_r <= 64'h0;
    end else begin
      pend_d_r <= pend;
    end
  end

  property p_arb_cause;
    @(posedge CLK_I) disable iff (!rst_n)
      ARB_VALID_O |-> pend_d_r[ARB_SOURCE_O] && ARB_LEVEL_O != `PRIO_OFF;
  endproperty
  a_arb_cause : assert property (p_arb_cause)
    else $error("Winner lacks flag, enable or level.");

  property p_irq_quiet;
    @(posedge CLK_I) disable iff (!rst_n)
      (pend == 64'h0) [*2] |-> !IRQ_O;
  endproperty
  a_irq_quiet : assert property (p_irq_quiet)
    else $error("Interrupt raised with nothing enabled pending.");

  property p_irq_rise;
    @(posedge CLK_I) disable iff (!rst_n)
      (pend != 64'h0) |=> IRQ_O;
  endproperty
  a_irq_rise : assert property (p_irq_rise)
    else $error("Enabled pending flag did not raise the interrupt.");

  property p_unmapped_zero;
    @(posedge CLK_I) disable iff (!rst_n)
      (state_r == ST_IDLE && AVS_READ_I && grp > `GRP_MISC) |=> AVS_READDATA_O == 32'h0;
  endproperty
  a_unmapped_zero : assert property (p_unmapped_zero)
    else $error("Unmapped read returned nonzero data.");

endmodule : interrupt_enable_bank
`default_nettype wire

// File: test/src_req_model.sv
/*
 * Behavioural model of the peripheral request sources.
 * Assumes the bench raises fire_i for one clock with the pattern to pulse.
 */
`timescale 1ns/1ns
`default_nettype none

module src_req_model (
  input  wire logic        clk_i,      // System clock.
  input  wire logic        fire_i,     // Pulse request from the bench.
  input  wire logic [63:0] pattern_i,  // Sources to pulse.
  output var  logic [63:0] req_o       // One-cycle request pulses.
);
  // ****************************************************************
  // Pulse generation
  // ****************************************************************
  // Each event is a single-cycle pulse; between events every line is low.
  always_ff @(posedge clk_i) begin
    req_o <= fire_i ? pattern_i : 64'h0;
  end
endmodule : src_req_model

`default_nettype wire

// File: test/interrupt_enable_bank_tb_top.sv
/*
 * Self-checking bench for the interrupt enable bank.
 * Assumes an Avalon-MM slave with waitrequest and the register map of the bank.
 */
`timescale 1ns/1ns
`default_nettype none

module interrupt_enable_bank_tb_top;
  import irq_bank_pkg::*;
  logic                clk;          // System clock, 50 ns period.
  logic                rst_n;        // Active low reset.
  logic [7:0]          addr;         // Bus byte address.
  logic                rd;           // Read request.
  logic                wr;           // Write request.
  logic [3:0]          be;           // Byte enables.
  logic [31:0]         wdata;        // Write data.
  logic [31:0]         rdata;        // Read data.
  logic                waitreq;      // Bus stall.
  logic [63:0]         src_req;      // Source pulses from the model.
  logic                irq;          // Level interrupt.
  logic                arb_valid;    // Winner valid.
  logic [5:0]          arb_src;      // Winner index.
  prio_t               arb_level;    // Winner level.
  logic                fire;         // Model pulse command.
  logic [63:0]         pattern;      // Model pulse pattern.
  logic [31:0]         got;          // Last read value.
  word_t               mask [4];     // Implemented bits of each word.
  int                  err_count;    // Mismatches seen.
  int                  n_compared;   // Comparisons made.

  // Clock generation.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  interrupt_enable_bank dut (
    .CLK_I(clk), .RESETN_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wdata),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .SRC_REQ_I(src_req),
    .IRQ_O(irq), .ARB_VALID_O(arb_valid), .ARB_SOURCE_O(arb_src), .ARB_LEVEL_O(arb_level)
  );

  src_req_model srcs (.clk_i(clk), .fire_i(fire), .pattern_i(pattern), .req_o(src_req));

  // ****************************************************************
  // Helper tasks
  // ****************************************************************
  // Prints the verdict and ends the run.
  task automatic results();
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One bus access; holds the request until the rising edge at which waitrequest
  // is sampled low, takes read data at that edge and only then releases.
  // Right after an edge the design's registers still show their pre-edge values.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= b;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    if (n == 20) begin
      err_count++;
      results();
    end
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  // Reads a register and compares it.
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    check(got, exp);
  endtask : rchk

  // Pulses the given sources through the model.
  task automatic pulse(input logic [63:0] p);
    @(posedge clk);
    fire <= 1'b1;
    pattern <= p;
    @(posedge clk);
    fire <= 1'b0;
  endtask : pulse

  // Holds reset for twelve cycles, then lets the synchroniser settle.
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    be = 4'h0;
    wdata = 32'h0;
    fire = 1'b0;
    pattern = 64'h0;
    err_count = 0;
    n_compared = 0;
    mask = '{16'h000b, 16'hdfff, 16'h21ff, 16'h00f6};
    do_reset();
    // Enables start cleared; all ones then 5a5a to the low byte read back through the mask.
    for (int w = 0; w < 4; w++) begin
      rchk(8'(4 * w), 32'h0);
      bus(1'b1, 8'(4 * w), 32'hffff_ffff, 4'hf);
      rchk(8'(4 * w), {16'h0, mask[w]});
      bus(1'b1, 8'(4 * w), 32'h0000_5a5a, 4'h1);
      rchk(8'(4 * w), {16'h0, mask[w] & 16'hff5a});
    end
    // Unmapped place reads zero.
    rchk(8'hf0, 32'h0);
    // Mid-run reset clears the enables again.
    do_reset();
    for (int w = 0; w < 4; w++) rchk(8'(4 * w), 32'h0);
    // Requests set the flags but stay masked.
    pulse(64'hffff_ffff_ffff_ffff);
    repeat (3) @(negedge clk);
    check(irq, 1'b0);
    for (int w = 0; w < 4; w++) begin
      rchk(8'(8'h10 + 4 * w), {16'h0, mask[w]});
      bus(1'b1, 8'(8'h10 + 4 * w), 32'h0, 4'hf);
      rchk(8'(8'h10 + 4 * w), {16'h0, mask[w]});
    end
    // Each enable bit alone raises the interrupt and a valid winner only where its position is implemented.
    for (int w = 0; w < 4; w++) begin
      for (int b = 0; b < 16; b++) begin
        bus(1'b1, 8'(4 * w), 32'(16'h1 << b), 4'h3);
        repeat (3) @(negedge clk);
        check(irq, mask[w][b]);
        check(arb_valid, mask[w][b]);
      end
      bus(1'b1, 8'(4 * w), 32'h0, 4'h3);
    end
    // Clearing every flag drops the request even with enables set.
    for (int w = 0; w < 4; w++) begin
      bus(1'b1, 8'(4 * w), 32'hffff, 4'h3);
      bus(1'b1, 8'(8'h20 + 4 * w), 32'hffff, 4'h3);
      rchk(8'(8'h10 + 4 * w), 32'h0);
      rchk(8'(8'h20 + 4 * w), 32'h0);
    end
    repeat (3) @(negedge clk);
    check(irq, 1'b0);
    // One pending source wins at its reset level, then at level seven.
    pulse(64'h1 << 38);
    repeat (3) @(negedge clk);
    check({arb_valid, arb_level, arb_src}, {1'b1, 3'h4, 6'd38});
    rchk(8'h38, {22'h0, 1'b1, 3'h4, 6'd38});
    // An unimplemented position has no priority and ignores writes.
    bus(1'b1, 8'h30, 32'd29, 4'h1);
    rchk(8'h30, 32'd29);
    bus(1'b1, 8'h34, 32'h7, 4'h1);
    rchk(8'h34, 32'h0);
    bus(1'b1, 8'h30, 32'd38, 4'h1);
    rchk(8'h34, 32'h4);
    bus(1'b1, 8'h34, 32'h7, 4'h1);
    repeat (3) @(negedge clk);
    check(arb_level, 3'h7);
    // Level zero keeps the source out of arbitration.
    bus(1'b1, 8'h34, 32'h0, 4'h1);
    repeat (3) @(negedge clk);
    check(arb_valid, 1'b0);
    check(irq, 1'b1);
    // A second source wins alone, then loses a tie to the lower index.
    pulse(64'h1 << 39);
    repeat (3) @(negedge clk);
    check({arb_valid, arb_level, arb_src}, {1'b1, 3'h4, 6'd39});
    bus(1'b1, 8'h34, 32'h4, 4'h1);
    repeat (3) @(negedge clk);
    check(arb_src, 6'd38);
    // Masking word three, and with it both sources, removes the interrupt.
    bus(1'b1, 8'h08, 32'h0, 4'h3);
    repeat (3) @(negedge clk);
    check(irq, 1'b0);
    results();
  end

  // Overall run limit.
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    results();
  end
endmodule : interrupt_enable_bank_tb_top

`default_nettype wire
